/* File: design/pwr_seq_top.sv */
// top: power-down freeze, power-up reset settling and readback security
// Behaviour
// - either sleep request high freezes the device
// - sleep only works when option configured
// - hold internal state and enabled outputs asleep
// - ignore pin changes until request drops
// - request pins unusable as user pins
// - reserved pin cell still makes foldback
// - power-up reset initialises registers and outputs
// - security fuse blocks pattern readback
// - signature and identity stay readable
// - registers change only on rising edges
`default_nettype none
module pwr_seq_top #(
	// at least two cells: the two lowest double as request pins
	parameter int unsigned N_CELLS = 8,
	parameter logic [31:0] DEV_ID = pwr_seq_pkg::DEV_ID_DEF, // value arbitrary
	parameter logic [15:0] USER_SIG = pwr_seq_pkg::USER_SIG_DEF // value arbitrary
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// configuration
	input wire logic sleep_enable_i,
	input wire logic security_fuse_i,
	input wire logic [N_CELLS-1:0] out_enable_i,
	input wire logic [N_CELLS-1:0] pol_inv_i,
	// sleep requests
	input wire logic sleep_request_a_i,
	input wire logic sleep_request_b_i,
	// user pins
	input wire logic [N_CELLS-1:0] user_in_i,
	output logic [N_CELLS-1:0] user_out_o,
	output logic [N_CELLS-1:0] user_oe_o,
	output logic [N_CELLS-1:0] foldback_o,
	// readback port
	input wire logic rd_req_i,
	input wire logic [1:0] rd_sel_i,
	input wire logic [31:0] pattern_i,
	output logic [31:0] rd_data_o,
	output logic rd_valid_o,
	output logic rd_denied_o,
	// status
	output logic sleeping_o,
	output logic ready_o
);
	////////////////////////////////////////////////////////////////////////
	// sequencer state
	pwr_seq_pkg::seq_state_t state_q;
	logic [pwr_seq_pkg::SETTLE_W-1:0] settle_q; // settling counter
	logic sleep_req; // either request, gated by option
	logic freeze; // holds every cell
	logic [N_CELLS-1:0] pin_in_q; // pin samples taken while awake
	logic [N_CELLS-1:0] cell_pin; // cell pin values
	logic [N_CELLS-1:0] cell_fb; // foldback terms
	logic [N_CELLS-1:0] reserved; // pins taken by sleep requests

	// request pins are the two lowest cells when the option is on
	// only this mask knows which cells the requests take
	function automatic logic [N_CELLS-1:0] reserve_mask(input logic en);
		logic [N_CELLS-1:0] m;
		m = '0;
		m[0] = en;
		m[1] = en;
		return m;
	endfunction : reserve_mask

	assign reserved = reserve_mask(sleep_enable_i);
	// requests are treated as synchronous pins, no synchroniser in front
	// either request or both; no effect without the option
	assign sleep_req = sleep_enable_i & (sleep_request_a_i | sleep_request_b_i);
	// frozen while asleep and while settling after power-up
	// settling freezes the cells too, so no pin sample lands before the
	// clock is trusted; the price is that the first user update waits
	assign freeze = (state_q != pwr_seq_pkg::ST_RUN);

	////////////////////////////////////////////////////////////////////////
	// state machine: settle after reset, then run or sleep
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= pwr_seq_pkg::ST_SETTLE;
		end else begin
			case (state_q)
				pwr_seq_pkg::ST_SETTLE: begin
					// system is expected to keep clock still here; we count anyway
					// the count only bounds the wait; it cannot see the supply itself
					if (settle_q >= pwr_seq_pkg::SETTLE_W'(pwr_seq_pkg::SETTLE_CYC - 1)) begin
						state_q <= pwr_seq_pkg::ST_RUN;
					end
				end
				pwr_seq_pkg::ST_RUN: begin
					if (sleep_req) begin
						state_q <= pwr_seq_pkg::ST_SLEEP;
					end
				end
				pwr_seq_pkg::ST_SLEEP: begin
					// wake straight into run, no re-initialisation
					// a request that rises again is simply seen on the next edge
					if (!sleep_req) begin
						state_q <= pwr_seq_pkg::ST_RUN;
					end
				end
				default: begin
					// unused code: back to settling, left again on the next edge since the count is not cleared
					state_q <= pwr_seq_pkg::ST_SETTLE;
				end
			endcase
		end
	end

	// settling counter, runs once after reset only
	// it stops one past the threshold, so it never wraps or restarts
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			settle_q <= '0;
		end else if (state_q == pwr_seq_pkg::ST_SETTLE) begin
			settle_q <= settle_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input capture: pin changes ignored while asleep
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_in_q <= '0;
		end else if (!sleep_req && state_q != pwr_seq_pkg::ST_SLEEP) begin
			// the request itself is looked at combinationally so the
			// first asleep cycle already drops the pin change
			// masked bits stay low so reserved pins never reach the cells
			pin_in_q <= user_in_i & ~reserved;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// user cells; cell data is its pin plus its left neighbour's foldback
	// the ring through the foldback terms keeps reserved cells in use
	for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
		logic d;
		assign d = pin_in_q[i] ^ cell_fb[(i + N_CELLS - 1) % N_CELLS];
		pd_cell u_cell (
			.clk_i(clk_i),
			.rst_n_i(rst_n_i),
			.freeze_i(freeze),
			.pol_inv_i(pol_inv_i[i]),
			.pin_reserved_i(reserved[i]),
			.d_i(d),
			.q_o(), // state reaches us through the foldback term
			.pin_o(cell_pin[i]),
			.foldback_o(cell_fb[i])
		);
	end

	// registered pin drivers; enables held with the data while asleep
	// a sleeping pin neither starts nor stops driving
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			user_out_o <= '0;
			user_oe_o <= '0;
			foldback_o <= '0;
		end else begin
			user_out_o <= cell_pin;
			foldback_o <= cell_fb;
			if (!freeze) begin
				user_oe_o <= out_enable_i & ~reserved;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// readback: pattern refused once fused, identity always allowed
	// answers stand one cycle and then drop back to zero unless a request is present on the next edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= '0;
			rd_valid_o <= 1'b0;
			rd_denied_o <= 1'b0;
		end else begin
			rd_valid_o <= 1'b0;
			rd_denied_o <= 1'b0;
			rd_data_o <= '0;
			if (rd_req_i) begin
				case (rd_sel_i)
					pwr_seq_pkg::RD_PATTERN: begin
						if (security_fuse_i) begin
							rd_denied_o <= 1'b1;
						end else begin
							rd_data_o <= pattern_i;
							rd_valid_o <= 1'b1;
						end
					end
					pwr_seq_pkg::RD_SIGNATURE: begin
						rd_data_o <= {16'h0000, USER_SIG};
						rd_valid_o <= 1'b1;
					end
					pwr_seq_pkg::RD_DEVICE_ID: begin
						rd_data_o <= DEV_ID;
						rd_valid_o <= 1'b1;
					end
					default: begin
						// a selector with no meaning is refused like a guarded pattern
						rd_denied_o <= 1'b1;
					end
				endcase
			end
		end
	end

	// status flags
	// one cycle behind the state, like user_oe_o; user_out_o lags by two
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sleeping_o <= 1'b0;
			ready_o <= 1'b0;
		end else begin
			sleeping_o <= (state_q == pwr_seq_pkg::ST_SLEEP);
			ready_o <= (state_q == pwr_seq_pkg::ST_RUN);
		end
	end
endmodule : pwr_seq_top
`default_nettype wire

/* File: design/pwr_seq_pkg.sv */
// package: constants for the power-down and power-up reset sequencer
`default_nettype none
package pwr_seq_pkg;
	// power-up reset settling time in ns, plain default
	localparam int unsigned SETTLE_NS = 100;
	localparam int unsigned CLK_NS = 10;
	// settling cycles, least time rounds up, zero only for a zero time
	localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	// counter width for the settling count
	localparam int unsigned SETTLE_W = 8;
	// reset value of every user register
	localparam logic RST_VAL = 1'b0;
	// arbitrary neutral identity codes
	localparam logic [31:0] DEV_ID_DEF = 32'h0000_0a5a;
	localparam logic [15:0] USER_SIG_DEF = 16'h1234;
	// readback selectors
	localparam logic [1:0] RD_PATTERN = 2'h0;
	localparam logic [1:0] RD_SIGNATURE = 2'h1;
	localparam logic [1:0] RD_DEVICE_ID = 2'h2;
	// sequencer states
	typedef enum logic [1:0] {
		ST_SETTLE,
		ST_RUN,
		ST_SLEEP
	} seq_state_t;
endpackage : pwr_seq_pkg
`default_nettype wire

/* File: design/pd_cell.sv */
// one user logic cell: register with freeze, output polarity and foldback term
`default_nettype none
module pd_cell (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic freeze_i,
	input wire logic pol_inv_i,
	input wire logic pin_reserved_i,
	// data
	input wire logic d_i,
	output logic q_o,
	output logic pin_o,
	output logic foldback_o
);
	// cell register, held while frozen
	logic state_q;

	// register updates only on rising clock edge, held while asleep
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= pwr_seq_pkg::RST_VAL;
		end else if (!freeze_i) begin
			state_q <= d_i;
		end
	end

	// pin value follows buffer polarity; a reserved pin carries no user data
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_o <= pwr_seq_pkg::RST_VAL;
		end else if (pin_reserved_i) begin
			pin_o <= pwr_seq_pkg::RST_VAL;
		end else if (!freeze_i) begin
			pin_o <= d_i ^ pol_inv_i;
		end
	end

	// internal term stays usable even with the pin reserved
	assign foldback_o = ~state_q;
	assign q_o = state_q;
endmodule : pd_cell
`default_nettype wire

/* File: verification/pwr_seq_props.sv */
// checker: port properties of the power sequencer
`default_nettype none
module pwr_seq_props #(
	parameter int unsigned N_CELLS = 8,
	parameter logic [15:0] USER_SIG = 16'h0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// configuration and requests
	input wire logic sleep_enable_i,
	input wire logic security_fuse_i,
	input wire logic sleep_request_a_i,
	input wire logic sleep_request_b_i,
	input wire logic rd_req_i,
	input wire logic [1:0] rd_sel_i,
	// design outputs
	input wire logic [N_CELLS-1:0] user_out_o,
	input wire logic [N_CELLS-1:0] user_oe_o,
	input wire logic [31:0] rd_data_o,
	input wire logic rd_valid_o,
	input wire logic rd_denied_o,
	input wire logic sleeping_o,
	input wire logic ready_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// either request pin counts
	wire logic req_w = sleep_request_a_i | sleep_request_b_i;
	////////////////////////////////////////////////////////////////////////
	chk_sleep_entry: assert property (ready_o && sleep_enable_i && req_w |-> ##2 sleeping_o)
		else $error("sleep not entered");
	chk_option_off: assert property ($rose(sleeping_o) |-> $past(sleep_enable_i, 2))
		else $error("sleep without option");
	chk_frozen_pins: assert property (sleeping_o && $past(sleeping_o) |->
		$stable(user_out_o) && $stable(user_oe_o)) else $error("pins moved asleep");
	chk_wake_bound: assert property (sleeping_o && !req_w |-> ##[1:2] !sleeping_o)
		else $error("late wake");
	// two stages of pipeline before the reserved pins settle
	chk_pins_reserved: assert property (sleep_enable_i && $past(sleep_enable_i) &&
		$past(sleep_enable_i, 2) |-> user_oe_o[1:0] == 2'h0 && user_out_o[1:0] == 2'h0)
		else $error("reserved pin driven");
	chk_fuse_denies: assert property (rd_req_i && security_fuse_i && rd_sel_i ==
		pwr_seq_pkg::RD_PATTERN |=> rd_denied_o && !rd_valid_o) else $error("pattern leaked");
	chk_sig_read: assert property (rd_req_i && rd_sel_i == pwr_seq_pkg::RD_SIGNATURE |=>
		rd_valid_o && rd_data_o == {16'h0, USER_SIG}) else $error("signature wrong");
	chk_settle_hold: assert property ($rose(rst_n_i) |->
		(!ready_o && !sleeping_o && user_out_o == '0) [*8]) else $error("settle broken");
	// main scenarios reached
	cover property (sleeping_o && $past(sleeping_o));
	cover property (rd_denied_o);
	cover property ($fell(sleeping_o));
endmodule : pwr_seq_props
bind pwr_seq_top pwr_seq_props #(.N_CELLS(N_CELLS), .USER_SIG(USER_SIG)) i_props (.*);
`default_nettype wire

/* File: verification/sys_logic_model.sv */
// model of the system logic that drives the sleep request pins
`default_nettype none
module sys_logic_model (
	// clock
	input wire logic clk_i,
	// wanted levels, bit 0 for pin a
	input wire logic [1:0] want_i,
	// request pins
	output logic sleep_request_a_o = 1'b0,
	output logic sleep_request_b_o = 1'b0
);
	// wanted levels taken on the rising edge, so no race with the bench
	logic [1:0] want_q = 2'h0;
	always @(posedge clk_i) begin
		want_q <= want_i;
	end
	// pins move on the falling edge, clear of the rising sample point
	always @(negedge clk_i) begin
		sleep_request_a_o <= want_q[0];
		sleep_request_b_o <= want_q[1];
	end
endmodule : sys_logic_model
`default_nettype wire

/* File: verification/pwr_seq_top_tb.sv */
// testbench: power sequencer driven by a model of the system logic
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module pwr_seq_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rst_n_i = 1'b0, sen = 1'b1, fuse = 1'b0, rq = 1'b0;
	logic [1:0] want = 2'h0, sel = 2'h0;
	logic [7:0] uin = 8'h00, pol = 8'h00, uout, uoe, held, fb, hfb;
	logic [31:0] rdata;
	logic rv, rdn, slp, rdy, ra, rb, fbc;
	int mismatches = 0, n_tests = 0;
	// readback rows: selector, fuse, answer valid, data
	typedef struct packed {logic [1:0] s; logic f; logic v; logic [31:0] d;} row_t;
	row_t rows [5] = '{'{2'h0, 1'b0, 1'b1, 32'h5a5a_c3c3}, '{2'h0, 1'b1, 1'b0, 32'h0},
		'{2'h1, 1'b1, 1'b1, {16'h0, pwr_seq_pkg::USER_SIG_DEF}},
		'{2'h2, 1'b1, 1'b1, pwr_seq_pkg::DEV_ID_DEF}, '{2'h3, 1'b0, 1'b0, 32'h0}};
	always #5 clk_i = ~clk_i;
	sys_logic_model i_sys (.clk_i(clk_i), .want_i(want), .sleep_request_a_o(ra),
		.sleep_request_b_o(rb));
	pwr_seq_top #(.N_CELLS(8)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sleep_enable_i(sen),
		.security_fuse_i(fuse), .out_enable_i(8'hff), .pol_inv_i(pol), .sleep_request_a_i(ra),
		.sleep_request_b_i(rb), .user_in_i(uin), .user_out_o(uout), .user_oe_o(uoe),
		.foldback_o(fb), .rd_req_i(rq), .rd_sel_i(sel), .pattern_i(32'h5a5a_c3c3),
		.rd_data_o(rdata), .rd_valid_o(rv), .rd_denied_o(rdn), .sleeping_o(slp), .ready_o(rdy));
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc
	task automatic report_and_stop();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(3);
		`CHK("rdy_rst", 1'b0, rdy)
		cyc(17);
		rst_n_i = 1'b1;
		for (int i = 0; i < 40 && rdy !== 1'b1; i++) cyc(1);
		`CHK("rdy", 1'b1, rdy)
		`CHK("oe_res", 2'h0, uoe[1:0])
		// back to back readbacks, request held high between rows
		foreach (rows[i]) begin
			fuse = rows[i].f;
			sel = rows[i].s;
			rq = 1'b1;
			cyc(1);
			`CHK("rv", rows[i].v, rv)
			`CHK("rdn", !rows[i].v, rdn)
			if (rows[i].v) `CHK("rdata", rows[i].d, rdata)
		end
		rq = 1'b0;
		// reserved cells keep feeding the foldback ring; pins follow polarity
		pol = 8'ha5;
		cyc(2);
		`CHK("out_res", 2'h0, uout[1:0])
		`CHK("pol", (~fb ^ pol) & 8'hfc, uout & 8'hfc)
		hfb = fb;
		fbc = 1'b0;
		for (int j = 0; j < 8; j++) begin
			cyc(1);
			if (fb[1:0] !== hfb[1:0]) fbc = 1'b1;
		end
		`CHK("fb_live", 1'b1, fbc)
		// sleep by pin a, pin b, then both
		for (int k = 1; k < 4; k++) begin
			uin = 8'h3c;
			cyc(4);
			want = 2'(k);
			cyc(4);
			`CHK("slp", 1'b1, slp)
			`CHK("rdy_slp", 1'b0, rdy)
			held = uout;
			hfb = fb;
			uin = 8'hc3;
			cyc(4);
			`CHK("held", held, uout)
			`CHK("fb_held", hfb, fb)
			want = 2'h0;
			cyc(4);
			`CHK("awake", 1'b0, slp)
			`CHK("rdy_wake", 1'b1, rdy)
		end
		// option off: requests must do nothing
		sen = 1'b0;
		cyc(3);
		want = 2'h3;
		cyc(5);
		`CHK("off", 1'b0, slp)
		// second power-up in mid-run: reset levels, settle, then run again
		rst_n_i = 1'b0;
		cyc(2);
		`CHK("out_rst2", 8'h00, uout)
		`CHK("rdy_rst2", 1'b0, rdy)
		rst_n_i = 1'b1;
		cyc(2);
		`CHK("settle2", 1'b0, rdy)
		for (int i = 0; i < 40 && rdy !== 1'b1; i++) cyc(1);
		`CHK("rdy2", 1'b1, rdy)
		`CHK("oe_free", 8'hff, uoe)
		`CHK("off2", 1'b0, slp)
		report_and_stop();
	end
	// hang guard, far beyond the roughly 120 cycles needed
	initial begin
		#20000;
		mismatches++;
		report_and_stop();
	end
endmodule : pwr_seq_top_tb
`default_nettype wire
